/* core/prgb_panel_rx.sv */
`timescale 1ns/1ps
`include "prgb_consts.svh"
// Summary of operation
// - capture inputs on pixel clock rising edge
// - display_on low standby, high display
// - line sync is horizontal reference
// - frame sync is vertical reference
// - pixel_valid qualifies active colour data
module prgb_panel_rx #(
	parameter int LINE_PIXELS = `PRGB_LINE_PIXELS,
	parameter int FRAME_LINES = `PRGB_FRAME_LINES,
	parameter int FIFO_DEPTH  = `PRGB_FIFO_DEPTH
) (
	input  wire logic                   i_clk_sys,
	input  wire logic                   i_reset,
	input  wire logic                   i_pixel_clock,
	input  wire logic                   i_display_on,
	input  wire logic                   i_line_sync_n,
	input  wire logic                   i_frame_sync_n,
	input  wire logic                   i_pixel_valid,
	input  wire logic [7:0]             i_red_bits,
	input  wire logic [7:0]             i_green_bits,
	input  wire logic [7:0]             i_blue_bits,
	output logic                        o_standby,
	output logic                        o_pix_valid,
	input  wire logic                   i_pix_ready,
	output prgb_pkg::prgb_word_s        o_pix,
	output logic [`PRGB_CNT_W-1:0]      o_col,
	output logic [`PRGB_CNT_W-1:0]      o_row,
	output logic                        o_overrun
);
	localparam int WW = $bits(prgb_pkg::prgb_word_s);

	// two-stage synchronisers for every pin
	logic [28:0] sync1;
	logic [28:0] sync2;
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			// idle levels, so no false sync edge follows reset
			sync1 <= `PRGB_SYNC_IDLE;
			sync2 <= `PRGB_SYNC_IDLE;
		end else begin
			sync1 <= {i_pixel_clock, i_display_on, i_line_sync_n,
				i_frame_sync_n, i_pixel_valid, i_red_bits,
				i_green_bits, i_blue_bits};
			sync2 <= sync1;
		end
	end

	logic pclk_s;
	logic display_on_s;
	logic hs_n_s;
	logic vs_n_s;
	logic de_s;
	prgb_pkg::prgb_pixel_s pix_s;
	assign {pclk_s, display_on_s, hs_n_s, vs_n_s, de_s} = sync2[28:24];
	assign pix_s = prgb_pkg::prgb_pixel_s'(sync2[23:0]);
	assign o_standby = !display_on_s;

	// pixel clock rising edge, found from synchronised samples.
	// limitation: data bits are sampled with the clock, so skew between
	// them must stay well under one system clock period
	logic pclk_d;
	logic pclk_rise;
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			pclk_d <= 1'b0;
		end else begin
			pclk_d <= pclk_s;
		end
	end
	assign pclk_rise = pclk_s && !pclk_d;

	// sync levels as seen on the previous pixel clock edge
	logic hs_prev;
	logic vs_prev;
	logic de_prev;
	logic hs_lead;
	logic vs_lead;
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			hs_prev <= 1'b0;
			vs_prev <= 1'b0;
			de_prev <= 1'b0;
		end else if (pclk_rise) begin
			hs_prev <= !hs_n_s;
			vs_prev <= !vs_n_s;
			de_prev <= de_s;
		end
	end
	assign hs_lead = pclk_rise && !hs_n_s && !hs_prev;
	assign vs_lead = pclk_rise && !vs_n_s && !vs_prev;

	prgb_pkg::prgb_mode_e mode;
	prgb_pkg::prgb_mode_e next_mode;
	always_comb begin
		next_mode = mode;
		unique case (mode)
			prgb_pkg::PRGB_STANDBY: begin
				if (display_on_s) begin
					next_mode = prgb_pkg::PRGB_WAIT_SYNC;
				end
			end
			prgb_pkg::PRGB_WAIT_SYNC: begin
				if (!display_on_s) begin
					next_mode = prgb_pkg::PRGB_STANDBY;
				end else if (vs_lead) begin
					next_mode = prgb_pkg::PRGB_RUN;
				end
			end
			prgb_pkg::PRGB_RUN: begin
				if (!display_on_s) begin
					next_mode = prgb_pkg::PRGB_STANDBY;
				end
			end
			default: next_mode = prgb_pkg::PRGB_STANDBY;
		endcase
	end

	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			mode <= prgb_pkg::PRGB_STANDBY;
		end else begin
			mode <= next_mode;
		end
	end

	logic running;
	logic take_pix;
	assign running = (mode == prgb_pkg::PRGB_RUN);
	assign take_pix = running && pclk_rise && de_s;

	// column and row positions of the active area
	logic [`PRGB_CNT_W-1:0] col;
	logic [`PRGB_CNT_W-1:0] row;
	logic                   line_used;
	logic                   first_line;
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			col        <= '0;
			row        <= '0;
			line_used  <= 1'b0;
			first_line <= 1'b1;
		end else if (!running || vs_lead) begin
			col        <= '0;
			row        <= '0;
			line_used  <= 1'b0;
			first_line <= 1'b1;
		end else if (hs_lead) begin
			col <= '0;
			if (line_used) begin
				row        <= row + 1'b1;
				first_line <= 1'b0;
			end
			line_used <= 1'b0;
		end else if (take_pix) begin
			col       <= col + 1'b1;
			line_used <= 1'b1;
		end
	end

	prgb_pkg::prgb_word_s wr_word;
	logic                 wr_ready;
	logic                 in_area;
	assign in_area = (col < `PRGB_CNT_W'(LINE_PIXELS)) &&
		(row < `PRGB_CNT_W'(FRAME_LINES));
	assign wr_word.pix            = pix_s;
	assign wr_word.first_in_line  = (col == '0);
	assign wr_word.first_in_frame = (col == '0) && first_line;

	// pixels beyond the documented area are dropped rather than wrapped
	logic push;
	assign push = take_pix && in_area;

	// the link cannot be stalled, so a full fifo can only be reported
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			o_overrun <= 1'b0;
		end else if (push && !wr_ready) begin
			// set wins over the frame-start clear
			o_overrun <= 1'b1;
		end else if (vs_lead) begin
			o_overrun <= 1'b0;
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			o_col <= '0;
			o_row <= '0;
		end else if (push && wr_ready) begin
			o_col <= col;
			o_row <= row;
		end
	end

	logic [WW-1:0] rd_data;
	prgb_fifo #(
		.WIDTH (WW),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.i_clk_sys  (i_clk_sys),
		.i_reset    (i_reset),
		.i_wr_valid (push),
		.o_wr_ready (wr_ready),
		.i_wr_data  (wr_word),
		.o_rd_valid (o_pix_valid),
		.i_rd_ready (i_pix_ready),
		.o_rd_data  (rd_data)
	);
	assign o_pix = prgb_pkg::prgb_word_s'(rd_data);

	standby_no_push_a: assert property (@(posedge i_clk_sys)
		disable iff (i_reset) !display_on_s |-> ##1 !push)
		else $error("pixel accepted in standby");
	invalid_no_push_a: assert property (@(posedge i_clk_sys)
		disable iff (i_reset) push |-> de_s && pclk_rise)
		else $error("pixel taken without valid edge");
	edge_capture_a: assert property (@(posedge i_clk_sys)
		disable iff (i_reset) push |-> !$past(pclk_s))
		else $error("capture off rising edge");
	line_restart_a: assert property (@(posedge i_clk_sys)
		disable iff (i_reset) running && hs_lead && !vs_lead
		|=> col == '0)
		else $error("column not reset by line sync");
	frame_restart_a: assert property (@(posedge i_clk_sys)
		disable iff (i_reset) vs_lead |=> row == '0 && col == '0)
		else $error("row not reset by frame sync");
	col_step_a: assert property (@(posedge i_clk_sys)
		disable iff (i_reset) take_pix && !hs_lead && !vs_lead
		|=> col == $past(col) + 1'b1)
		else $error("column did not advance");
	pixel_path_a: assert property (@(posedge i_clk_sys)
		disable iff (i_reset) push |-> wr_word.pix == sync2[23:0])
		else $error("pixel bits reordered");
	wake_wait_a: assert property (@(posedge i_clk_sys)
		disable iff (i_reset) mode == prgb_pkg::PRGB_STANDBY && display_on_s
		|=> mode == prgb_pkg::PRGB_WAIT_SYNC)
		else $error("no wake on display_on");
	overrun_set_a: assert property (@(posedge i_clk_sys)
		disable iff (i_reset) push && !wr_ready |=> o_overrun)
		else $error("overrun not flagged");
endmodule

/* core/prgb_consts.svh */
`ifndef PRGB_CONSTS_SVH
`define PRGB_CONSTS_SVH
`define PRGB_COLOR_BITS  8
`define PRGB_LINE_PIXELS 480
`define PRGB_FRAME_LINES 272
`define PRGB_FIFO_DEPTH  8
`define PRGB_PIX_W       24
`define PRGB_CNT_W       10
// synchroniser reset: both active-low syncs at their idle high level
`define PRGB_SYNC_IDLE   29'h0600_0000
`endif

/* core/prgb_pkg.sv */
package prgb_pkg;
	typedef struct packed {
		logic [7:0] red_bits;
		logic [7:0] green_bits;
		logic [7:0] blue_bits;
	} prgb_pixel_s;

	typedef struct packed {
		prgb_pixel_s pix;
		logic        first_in_line;
		logic        first_in_frame;
	} prgb_word_s;

	typedef enum logic [1:0] {
		PRGB_STANDBY   = 2'b00,
		PRGB_WAIT_SYNC = 2'b01,
		PRGB_RUN       = 2'b10
	} prgb_mode_e;
endpackage

/* core/prgb_fifo.sv */
`timescale 1ns/1ps
module prgb_fifo #(
	parameter int WIDTH = 26,
	parameter int DEPTH = 8
) (
	input  wire logic             i_clk_sys,
	input  wire logic             i_reset,
	input  wire logic             i_wr_valid,
	output logic                  o_wr_ready,
	input  wire logic [WIDTH-1:0] i_wr_data,
	output logic                  o_rd_valid,
	input  wire logic             i_rd_ready,
	output logic      [WIDTH-1:0] o_rd_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic             do_wr;
	logic             do_rd;

	assign o_wr_ready = (count != (AW+1)'(DEPTH));
	assign o_rd_valid = (count != '0);
	assign do_wr      = i_wr_valid && o_wr_ready;
	assign do_rd      = o_rd_valid && i_rd_ready;
	assign o_rd_data  = mem[rd_ptr];

	always_ff @(posedge i_clk_sys) begin
		if (do_wr) begin
			mem[wr_ptr] <= i_wr_data;
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (do_wr) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
			end
			if (do_rd) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
			end
			count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
		end
	end

	// overflow guard
	fifo_no_overflow_a: assert property (@(posedge i_clk_sys)
		disable iff (i_reset) count <= (AW+1)'(DEPTH))
		else $error("fifo count above depth");
endmodule

/* bench/prgb_host.sv */
`timescale 1ns/1ps
module prgb_host #(
	parameter int PIXELS = 12,
	parameter int LINES  = 3
) (
	output logic        o_pixel_clock,
	output logic        o_line_sync_n,
	output logic        o_frame_sync_n,
	output logic        o_pixel_valid,
	output logic [23:0] o_rgb
);
	logic [7:0] junk;

	initial begin
		{o_pixel_clock, o_pixel_valid, o_rgb} = '0;
		{o_line_sync_n, o_frame_sync_n} = 2'b11;
		junk = 8'h00;
	end

	task automatic tick(input logic hs, vs, de, input logic [23:0] px);
		{o_line_sync_n, o_frame_sync_n, o_pixel_valid} = {hs, vs, de};
		o_rgb = de ? px : {3{junk}};
		junk = junk + 8'h5b;
		// clock scaled to 320 ns period
		#160 o_pixel_clock = 1'b1;
		#160 o_pixel_clock = 1'b0;
	endtask

	task automatic line(input logic vs, act, input logic [7:0] b, row);
		repeat (2) tick(1'b0, vs, 1'b0, '0);
		tick(1'b1, vs, 1'b0, '0);
		for (int c = 0; c < PIXELS; c++) begin
			tick(1'b1, vs, act, {b, row, 8'(c)});
		end
		repeat (2) tick(1'b1, vs, 1'b0, '0);
	endtask

	// line and frame periods scaled
	// scaled counts: whole frames stay short in simulation
	task automatic frame(input logic [7:0] b);
		repeat (2) line(1'b0, 1'b0, b, 8'h00);
		repeat (2) line(1'b1, 1'b0, b, 8'h00);
		for (int r = 0; r < LINES; r++) begin
			line(1'b1, 1'b1, b, 8'(r));
		end
		repeat (2) line(1'b1, 1'b0, b, 8'h00);
	endtask
endmodule

/* bench/tb.sv */
`timescale 1ns/1ps
`define CHK(act, exp, msg) begin \
	checks_done++; \
	if ((act) !== (exp)) begin \
		error_cnt++; \
		$display("unexpected at %0t: %s", $time, msg); \
	end \
end
module tb;
	localparam int PIX  = 12;
	localparam int ROWS = 3;
	localparam int DEEP = 8;
	logic                 clk_sys = 1'b0;
	logic                 reset   = 1'b1;
	logic                 display_on_on = 1'b0;
	logic                 ready   = 1'b0;
	wire logic            pclk;
	wire logic            hs_n;
	wire logic            vs_n;
	wire logic            de;
	wire logic [23:0]     rgb;
	logic                 standby;
	logic                 pvalid;
	logic                 overrun;
	prgb_pkg::prgb_word_s pix;
	prgb_pkg::prgb_word_s exp;
	logic [9:0]           col;
	logic [9:0]           row;
	logic [7:0]           base = 8'h00;
	int                   error_cnt = 0;
	int                   checks_done = 0;
	int                   cycles = 0;
	int                   got = 0;

	always #20 clk_sys = ~clk_sys;

	prgb_host #(.PIXELS(PIX), .LINES(ROWS)) host (
		.o_pixel_clock  (pclk),
		.o_line_sync_n  (hs_n),
		.o_frame_sync_n (vs_n),
		.o_pixel_valid  (de),
		.o_rgb          (rgb)
	);

	prgb_panel_rx #(.LINE_PIXELS(PIX), .FRAME_LINES(ROWS),
		.FIFO_DEPTH(DEEP)) DUT (
		.i_clk_sys      (clk_sys),
		.i_reset        (reset),
		.i_pixel_clock  (pclk),
		.i_display_on   (display_on_on),
		.i_line_sync_n  (hs_n),
		.i_frame_sync_n (vs_n),
		.i_pixel_valid  (de),
		.i_red_bits     (rgb[23:16]),
		.i_green_bits   (rgb[15:8]),
		.i_blue_bits    (rgb[7:0]),
		.o_standby      (standby),
		.o_pix_valid    (pvalid),
		.i_pix_ready    (ready),
		.o_pix          (pix),
		.o_col          (col),
		.o_row          (row),
		.o_overrun      (overrun)
	);

	task automatic finish_test();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// consumer side: each popped word against its raster position
	always @(posedge clk_sys) begin
		if (pvalid === 1'b1 && ready === 1'b1) begin
			exp = {base, 8'(got / PIX), 8'(got % PIX),
				got % PIX == 0, got == 0};
			`CHK(pix, exp, "pixel word")
			got++;
		end
	end

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			error_cnt++;
			$display("unexpected at %0t: run hung", $time);
			finish_test();
		end
	end

	task automatic run_frame(input logic [7:0] b, input int n);
		base = b;
		got = 0;
		host.frame(b);
		repeat (20) @(negedge clk_sys);
		`CHK(got, n, "word count")
		$display("frame %0h done", b);
	endtask

	initial begin
		repeat (9) @(negedge clk_sys);
		reset = 1'b0;
		repeat (4) @(negedge clk_sys);
		`CHK(standby, 1'b1, "standby flag")
		run_frame(8'h11, 0);
		display_on_on = 1'b1;
		ready = 1'b1;
		repeat (8) @(negedge clk_sys);
		`CHK(standby, 1'b0, "display flag")
		run_frame(8'ha5, PIX * ROWS);
		`CHK(col, 10'(PIX - 1), "last column")
		`CHK(row, 10'(ROWS - 1), "last row")
		// far side stalls: fifo fills, refuses, then drains
		ready = 1'b0;
		run_frame(8'h3c, 0);
		`CHK(overrun, 1'b1, "overrun set")
		ready = 1'b1;
		repeat (20) @(negedge clk_sys);
		`CHK(got, DEEP, "kept words")
		`CHK(pvalid, 1'b0, "fifo empty")
		run_frame(8'h77, PIX * ROWS);
		`CHK(overrun, 1'b0, "overrun cleared")
		display_on_on = 1'b0;
		repeat (8) @(negedge clk_sys);
		run_frame(8'h5e, 0);
		// woken panel refuses a line before frame sync
		display_on_on = 1'b1;
		got = 0;
		repeat (8) @(negedge clk_sys);
		host.line(1'b1, 1'b1, 8'h99, 8'h00);
		repeat (20) @(negedge clk_sys);
		`CHK(got, 0, "pixels before frame sync")
		$display("early line done");
		run_frame(8'h42, PIX * ROWS);
		finish_test();
	end
endmodule
